//--- core/pmw_pkg.sv
// Package: register map, field layout, timing and types of the power and wake block
package pmw_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int NPHY    = 2;
  localparam int NPORT   = 3;
  localparam int STRAP_W = 4;
  localparam int NWAKE   = 3;
  localparam int NSTA    = 6;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_PWR_CTRL  = 8'h00;
  localparam logic [7:0] REG_PORT_PD   = 8'h01;
  localparam logic [7:0] REG_EEE_CTRL  = 8'h02;
  localparam logic [7:0] REG_ED_TMO    = 8'h03;
  localparam logic [7:0] REG_WAKE_TIME = 8'h04;
  localparam logic [7:0] REG_WAKE_CFG  = 8'h05;
  localparam logic [7:0] REG_WAKE_STAT = 8'h06;
  localparam logic [7:0] REG_STATUS    = 8'h07;
  localparam logic [7:0] REG_STA_BASE  = 8'h08;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE_LO    = 3;
  localparam int MODE_HI    = 4;
  localparam int RXLPI_LO   = 2;
  localparam int PMESEL_BIT = 4;
  localparam logic [7:0] ED_TMO_RST    = 8'h10;
  localparam logic [7:0] WAKE_TIME_RST = 8'h10;
  localparam logic [7:0] SYNC_BYTE     = 8'hFF;
  localparam logic [3:0] SYNC_COUNT    = 4'h6;
  localparam logic [3:0] ADDR_REPEATS  = 4'hF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS        = 50;
  localparam int ENERGY_NS     = 100;
  localparam int ENERGY_CYC    = (ENERGY_NS + CLK_NS - 1) / CLK_NS;
  localparam int REFRESH_US    = 200;
  localparam int REFRESH_CYC   = (REFRESH_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int REFRESH_MS    = 20;
  localparam int LINK_PULSE_MS = 16;
  localparam int LINK_PULSE_W  = ENERGY_CYC;
  localparam int LPI_RX_CLKS   = 9;
  localparam int TMO_SHIFT     = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_ENERGY_DETECT_POWERDOWN   = 2'b01,
    MODE_SOFTPD = 2'b10
  } pmw_mode_e;

  typedef enum logic [1:0] {
    ED_OFF    = 2'b00,
    ED_ACTIVE = 2'b01,
    ED_LOW    = 2'b11
  } pmw_ed_e;

  typedef struct packed {
    logic       sof;
    logic       valid;
    logic [7:0] data;
  } pmw_rx_s;

  typedef struct packed {
    logic pllEn;
    logic phyEn;
    logic macEn;
    logic edOnly;
    logic linkPulse;
  } pmw_pwr_s;

endpackage : pmw_pkg

//--- core/pmw_power_wake_ctrl.sv
// Global power modes, energy-detect sequencing, EEE idle control and wake reporting
//
// Our own choices: the register addresses and the address-and-strobe port.
module pmw_power_wake_ctrl #(
  parameter int REFRESH_PERIOD_CYC = pmw_pkg::REFRESH_MS * 1000000 / pmw_pkg::CLK_NS,
  parameter int LINK_PULSE_CYC     = pmw_pkg::LINK_PULSE_MS * 1000000 / pmw_pkg::CLK_NS
) (
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  // Register port
  input  wire logic [7:0]                   regAddr,
  input  wire logic [7:0]                   regWrData,
  input  wire logic                         regWr,
  input  wire logic                         regRd,
  output logic      [7:0]                   regRdData,
  // Asynchronous pins
  input  wire logic                         cableEnergy,
  input  wire logic [pmw_pkg::NPHY-1:0]     linkUpPin,
  input  wire logic [pmw_pkg::STRAP_W-1:0]  strapPin,
  // EEE handshakes, same clock
  input  wire logic [pmw_pkg::NPHY-1:0]     anegLocalEee,
  input  wire logic [pmw_pkg::NPHY-1:0]     anegPartnerEee,
  input  wire logic [pmw_pkg::NPHY-1:0]     macLpiReq,
  input  wire logic [pmw_pkg::NPHY-1:0]     rxCodeValid,
  input  wire logic [pmw_pkg::NPHY-1:0]     rxCodeRefresh,
  // Received byte stream
  input  wire pmw_pkg::pmw_rx_s             rxByte,
  // Power controls
  output pmw_pkg::pmw_pwr_s                 pwr,
  output logic [pmw_pkg::NPORT-1:0]         portPowerDown,
  output logic [pmw_pkg::STRAP_W-1:0]       strapVal,
  // EEE state
  output logic [pmw_pkg::NPHY-1:0]          txLpi,
  output logic [pmw_pkg::NPHY-1:0]          txRefresh,
  output logic [pmw_pkg::NPHY-1:0]          rxLpi,
  output logic [pmw_pkg::NPHY-1:0]          rxClkStop,
  // Wake notification
  output logic                              hostIrqN,
  output logic                              powerEventN
);
  import pmw_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYN_W = 1 + NPHY + STRAP_W;
  logic [SYN_W-1:0] syncA;
  logic [SYN_W-1:0] syncB;
  logic             energyS;
  logic [NPHY-1:0]  linkS;
  logic [STRAP_W-1:0] strapS;

  // Two stages; only syncB feeds logic
  always_ff @(posedge sys_clk) begin
    syncA <= {cableEnergy, linkUpPin, strapPin};
    syncB <= syncA;
  end
  assign {energyS, linkS, strapS} = syncB;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  pmw_mode_e          mode;
  logic [NPORT-1:0]   portPd;
  logic [NPHY-1:0]    eeeEn;
  logic [NPHY-1:0]    rxLpiEn;
  logic [7:0]         edTmo;
  logic [7:0]         wakeTime;
  logic [NWAKE-1:0]   wakeEn;
  logic               pmeSel;
  logic [NWAKE-1:0]   wakeFlag;
  logic [7:0]         station [NSTA];
  logic               strapTake;

  // Write decode
  wire wrMode  = regWr && regAddr == REG_PWR_CTRL;
  wire [1:0] wrModeVal = regWrData[MODE_HI:MODE_LO];
  wire modeOk  = wrModeVal != 2'b11;
  wire isSoft  = mode == MODE_SOFTPD;
  wire pdExit  = wrMode && isSoft && modeOk && wrModeVal != MODE_SOFTPD;
  wire cfgRst  = rst || pdExit;
  wire wrPortPd = regWr && regAddr == REG_PORT_PD;
  wire wrEee    = regWr && regAddr == REG_EEE_CTRL;
  wire wrEdTmo  = regWr && regAddr == REG_ED_TMO;
  wire wrWTime  = regWr && regAddr == REG_WAKE_TIME;
  wire wrWCfg   = regWr && regAddr == REG_WAKE_CFG;
  wire [NWAKE-1:0] wakeClr =
    (regWr && regAddr == REG_WAKE_STAT) ? regWrData[NWAKE-1:0] : '0;

  // Mode field; the reserved code 11 is ignored so one mode always holds
  always_ff @(posedge sys_clk) begin
    if (cfgRst) begin
      mode <= MODE_NORMAL;
    end else if (wrMode && modeOk) begin
      mode <= pmw_mode_e'(wrModeVal);
    end
  end

  // Configuration registers, restored together on soft power-down exit
  always_ff @(posedge sys_clk) begin
    if (cfgRst) begin
      portPd   <= '0;
      eeeEn    <= '0;
      rxLpiEn  <= '0;
      edTmo    <= ED_TMO_RST;
      wakeTime <= WAKE_TIME_RST;
      wakeEn   <= '0;
      pmeSel   <= 1'b0;
    end else begin
      if (wrPortPd) portPd <= regWrData[NPORT-1:0];
      if (wrEee) eeeEn <= regWrData[NPHY-1:0];
      if (wrEee) rxLpiEn <= regWrData[RXLPI_LO+NPHY-1:RXLPI_LO];
      if (wrEdTmo) edTmo <= regWrData;
      if (wrWTime) wakeTime <= regWrData;
      if (wrWCfg) wakeEn <= regWrData[NWAKE-1:0];
      if (wrWCfg) pmeSel <= regWrData[PMESEL_BIT];
    end
  end

  // Station address bytes, one register per byte
  for (genvar s = 0; s < NSTA; s++) begin : g_sta
    always_ff @(posedge sys_clk) begin
      if (cfgRst) begin
        station[s] <= 8'h00;
      end else if (regWr && regAddr == REG_STA_BASE + 8'(s)) begin
        station[s] <= regWrData;
      end
    end
  end

  // Straps caught at the first edge after reset or soft power-down exit
  always_ff @(posedge sys_clk) begin
    if (cfgRst) begin
      strapTake <= 1'b1;
      strapVal  <= '0;
    end else begin
      strapTake <= 1'b0;
      if (strapTake) strapVal <= strapS;
    end
  end

  // ----------------------------------------------------------------
  // Energy-detect state machine
  // ----------------------------------------------------------------
  pmw_ed_e    edState;
  pmw_ed_e    next_edState;
  logic [15:0] quietCnt;
  logic [2:0]  energyCnt;
  logic [23:0] pulseCnt;
  wire  [15:0] edTmoCyc = {edTmo, 8'h00};
  wire  quietOver = quietCnt >= edTmoCyc;
  wire  energyLong = energyS && energyCnt >= 3'(ENERGY_CYC);
  wire  isEdpd = mode == MODE_ENERGY_DETECT_POWERDOWN;

  // Quiet time is measured only in the normal-power state
  always_comb begin
    next_edState = edState;
    case (edState)
      ED_OFF: begin
        if (isEdpd) next_edState = ED_ACTIVE;
      end
      ED_ACTIVE: begin
        if (!isEdpd) next_edState = ED_OFF;
        else if (quietOver) next_edState = ED_LOW;
      end
      ED_LOW: begin
        if (!isEdpd) next_edState = ED_OFF;
        else if (energyLong) next_edState = ED_ACTIVE;
      end
      default: next_edState = ED_OFF;
    endcase
  end

  // Counters saturate so a long quiet cable never wraps back
  always_ff @(posedge sys_clk) begin
    if (cfgRst) begin
      edState   <= ED_OFF;
      quietCnt  <= '0;
      energyCnt <= '0;
    end else begin
      edState   <= next_edState;
      quietCnt  <= (edState == ED_ACTIVE && !energyS && !quietOver) ? quietCnt + 16'h1
                 : (edState == ED_ACTIVE && !energyS) ? quietCnt : 16'h0;
      energyCnt <= (edState == ED_LOW && energyS && !energyLong) ? energyCnt + 3'h1
                 : (edState == ED_LOW && energyS) ? energyCnt : 3'h0;
    end
  end

  // Sparse link pulses while in the low-power state
  wire pulseWrap = pulseCnt >= 24'(LINK_PULSE_CYC - 1);
  always_ff @(posedge sys_clk) begin
    if (cfgRst || next_edState != ED_LOW) begin
      pulseCnt <= '0;
    end else begin
      pulseCnt <= pulseWrap ? 24'h0 : pulseCnt + 24'h1;
    end
  end

  // Global enables; the management port itself is never gated
  wire lowPower = isSoft || next_edState == ED_LOW;
  always_ff @(posedge sys_clk) begin
    if (cfgRst) begin
      pwr <= '{pllEn: 1'b1, phyEn: 1'b1, macEn: 1'b1, edOnly: 1'b0, linkPulse: 1'b0};
    end else begin
      pwr.pllEn     <= !lowPower;
      pwr.phyEn     <= !lowPower;
      pwr.macEn     <= !lowPower;
      pwr.edOnly    <= next_edState == ED_LOW;
      pwr.linkPulse <= next_edState == ED_LOW && pulseCnt < 24'(LINK_PULSE_W);
    end
  end

  // Per-port power-down is separate from the global mode
  always_ff @(posedge sys_clk) begin
    if (cfgRst) portPowerDown <= '0;
    else portPowerDown <= portPd;
  end

  // ----------------------------------------------------------------
  // EEE per PHY port; the MAC port has no idle logic at all
  // ----------------------------------------------------------------
  logic [NPHY-1:0] eeeActive;
  logic [23:0]     refCnt [NPHY];
  logic [3:0]      rxCnt  [NPHY];

  for (genvar p = 0; p < NPHY; p++) begin : g_eee
    assign eeeActive[p] = eeeEn[p] && anegLocalEee[p] && anegPartnerEee[p];
    wire next_tx = eeeActive[p] && macLpiReq[p];
    wire refWrap = refCnt[p] >= 24'(REFRESH_PERIOD_CYC - 1);
    wire rxOn = eeeActive[p] && rxLpiEn[p];
    wire next_rx = !rxOn ? 1'b0
                 : rxCodeValid[p] ? rxCodeRefresh[p] : rxLpi[p];

    // Transmit side: refresh burst at the start of every period
    always_ff @(posedge sys_clk) begin
      if (cfgRst) begin
        txLpi[p]     <= 1'b0;
        txRefresh[p] <= 1'b0;
        refCnt[p]    <= '0;
      end else begin
        txLpi[p]     <= next_tx;
        refCnt[p]    <= (!next_tx || refWrap) ? 24'h0 : refCnt[p] + 24'h1;
        txRefresh[p] <= next_tx && refCnt[p] < 24'(REFRESH_CYC);
      end
    end

    // Receive side: clock stop only after the minimum idle dwell
    always_ff @(posedge sys_clk) begin
      if (cfgRst) begin
        rxLpi[p]     <= 1'b0;
        rxCnt[p]     <= '0;
        rxClkStop[p] <= 1'b0;
      end else begin
        rxLpi[p]     <= next_rx;
        rxCnt[p]     <= !rxLpi[p] ? 4'h0 : (rxCnt[p] == 4'hF) ? rxCnt[p] : rxCnt[p] + 4'h1;
        rxClkStop[p] <= next_rx && rxLpi[p] && rxCnt[p] >= 4'(LPI_RX_CLKS - 1);
      end
    end

    // Idle on either port only with both ends advertising it
    chk_tx_lpi: assert property (@(posedge sys_clk) disable iff (rst)
      txLpi[p] |-> $past(eeeEn[p]) && $past(anegLocalEee[p]) && $past(anegPartnerEee[p]))
      else $error("transmit idle without negotiated request");

    chk_rx_clk9: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(rxClkStop[p]) |-> $past(rxLpi[p], 9) && rxLpi[p])
      else $error("receive clock stopped too early");
  end

  // ----------------------------------------------------------------
  // Wake packet scanner
  // ----------------------------------------------------------------
  logic [3:0] ffCnt;
  logic [2:0] byteSel;
  logic [3:0] repCnt;
  logic       pktHit;
  wire  isFf     = rxByte.data == SYNC_BYTE;
  wire  inSync   = ffCnt >= SYNC_COUNT;
  wire  staMatch = rxByte.data == station[byteSel];
  wire  lastByte = byteSel == 3'(NSTA - 1);
  wire  atStart  = byteSel == 3'h0 && repCnt == 4'h0;

  // Mismatch restarts the search; extra FF bytes keep the sync
  always_ff @(posedge sys_clk) begin
    if (cfgRst || rxByte.sof) begin
      ffCnt   <= '0;
      byteSel <= '0;
      repCnt  <= '0;
      pktHit  <= 1'b0;
    end else begin
      pktHit <= 1'b0;
      if (rxByte.valid) begin
        if (!inSync) begin
          ffCnt <= isFf ? ffCnt + 4'h1 : 4'h0;
        end else if (staMatch) begin
          byteSel <= lastByte ? 3'h0 : byteSel + 3'h1;
          if (lastByte) repCnt <= repCnt + 4'h1;
          if (lastByte && repCnt == ADDR_REPEATS) begin
            pktHit <= 1'b1;
            ffCnt  <= '0;
          end
        end else if (!(atStart && isFf)) begin
          ffCnt   <= isFf ? 4'h1 : 4'h0;
          byteSel <= '0;
          repCnt  <= '0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Wake events and notification pins
  // ----------------------------------------------------------------
  logic [15:0]     wakeECnt;
  logic [NPHY-1:0] linkPrev;
  wire  [15:0]     wakeCyc = {wakeTime, 8'h00};
  wire  evEnergy = energyS && wakeECnt == wakeCyc;
  wire  evLink   = |(linkS & ~linkPrev);
  wire  [NWAKE-1:0] events = {pktHit, evLink, evEnergy} & wakeEn;
  wire  [NWAKE-1:0] next_wakeFlag = (wakeFlag & ~wakeClr) | events;
  wire  anyWake = |next_wakeFlag;

  // Set beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (cfgRst) begin
      wakeECnt <= '0;
      linkPrev <= '0;
      wakeFlag <= '0;
    end else begin
      wakeECnt <= !energyS ? 16'h0 : (wakeECnt > wakeCyc) ? wakeECnt : wakeECnt + 16'h1;
      linkPrev <= linkS;
      wakeFlag <= next_wakeFlag;
    end
  end

  // Pins follow the flags and the chosen destination
  always_ff @(posedge sys_clk) begin
    if (cfgRst) begin
      hostIrqN    <= 1'b1;
      powerEventN <= 1'b1;
    end else begin
      hostIrqN    <= !(anyWake && !pmeSel);
      powerEventN <= !(anyWake && pmeSel);
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  wire [7:0] staIdx = regAddr - REG_STA_BASE;
  wire staHit = regAddr >= REG_STA_BASE && staIdx < 8'(NSTA);
  wire [7:0] rdMux =
      regAddr == REG_PWR_CTRL  ? {3'h0, mode, 3'h0}
    : regAddr == REG_PORT_PD   ? {5'h0, portPd}
    : regAddr == REG_EEE_CTRL  ? {4'h0, rxLpiEn, eeeEn}
    : regAddr == REG_ED_TMO    ? edTmo
    : regAddr == REG_WAKE_TIME ? wakeTime
    : regAddr == REG_WAKE_CFG  ? {3'h0, pmeSel, 1'b0, wakeEn}
    : regAddr == REG_WAKE_STAT ? {5'h0, wakeFlag}
    : regAddr == REG_STATUS    ? {2'h0, rxLpi, txLpi, edState}
    : staHit                   ? station[staIdx[2:0]]
    : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) regRdData <= 8'h00;
    else regRdData <= regRd ? rdMux : 8'h00;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_mode_onehot: assert property (@(posedge sys_clk) disable iff (rst)
    $onehot({mode == MODE_NORMAL, mode == MODE_ENERGY_DETECT_POWERDOWN, isSoft}))
    else $error("global mode not exactly one");

  chk_reset_normal: assert property (@(posedge sys_clk) rst |=>
    mode == MODE_NORMAL && eeeEn == '0 && edState == ED_OFF)
    else $error("reset did not give normal mode");

  chk_energy_detect_powerdown_select: assert property (@(posedge sys_clk) disable iff (rst)
    wrMode && wrModeVal == MODE_ENERGY_DETECT_POWERDOWN && !isSoft |=> ##1 edState != ED_OFF)
    else $error("energy-detect mode not entered");

  chk_ed_enter: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(edState == ED_LOW) |-> $past(quietCnt) >= $past(edTmoCyc))
    else $error("low-power state entered before timeout");

  chk_ed_exit: assert property (@(posedge sys_clk) disable iff (rst)
    (edState == ED_LOW && isEdpd && energyS)[*3] |=> edState == ED_ACTIVE)
    else $error("energy did not wake from low-power state");

  chk_ed_gating: assert property (@(posedge sys_clk) disable iff (rst)
    edState == ED_LOW |-> pwr.edOnly && !pwr.macEn && !pwr.pllEn && !pwr.phyEn)
    else $error("circuits left on in low-power state");

  chk_soft_off: assert property (@(posedge sys_clk) disable iff (rst)
    isSoft && !pdExit |=> !pwr.macEn && !pwr.phyEn && !pwr.pllEn)
    else $error("function left on in soft power-down");

  chk_wake_hold: assert property (@(posedge sys_clk) disable iff (rst)
    wakeFlag[1] && !wakeClr[1] && !pdExit |=> wakeFlag[1])
    else $error("wake flag lost without clear");

  chk_irq_pin: assert property (@(posedge sys_clk) disable iff (rst)
    |wakeFlag && !pmeSel && !pdExit |-> ##[0:1] !hostIrqN)
    else $error("interrupt pin not asserted for wake");

endmodule : pmw_power_wake_ctrl

//--- bench/pmw_link_partner.sv
// Cable link partner model: energy, link state, line codes and idle byte lane
module pmw_link_partner (
  // Clock
  input  wire logic        sys_clk,
  // Commands from the bench
  input  wire logic        energyOn,
  input  wire logic [1:0]  linkOn,
  input  wire logic [1:0]  refreshOn,
  input  wire logic [1:0]  dataOn,
  // Frame bytes from the bench
  input  wire logic        pktSof,
  input  wire logic        pktValid,
  input  wire logic [7:0]  pktByte,
  // Line side
  output logic             cableEnergy,
  output logic [1:0]       linkUpPin,
  output logic [1:0]       rxCodeValid,
  output logic [1:0]       rxCodeRefresh,
  output pmw_pkg::pmw_rx_s rxByte
);
  timeunit 1ns;
  timeprecision 1ns;
  import pmw_pkg::*;
  logic [7:0] idleCnt;
  initial begin
    idleCnt = 8'h00;
    {cableEnergy, linkUpPin, rxCodeValid, rxCodeRefresh, rxByte} = '0;
  end
  // Idle lane data changes every cycle so no stale byte can pass as a match
  always @(posedge sys_clk) begin
    idleCnt       <= idleCnt + 8'h01;
    cableEnergy   <= energyOn;
    linkUpPin     <= linkOn;
    rxCodeValid   <= refreshOn | dataOn;
    rxCodeRefresh <= refreshOn;
    rxByte        <= '{sof: pktSof, valid: pktValid, data: pktValid ? pktByte : idleCnt};
  end
endmodule : pmw_link_partner

//--- bench/tb.sv
// Self-checking bench of the power, idle and wake block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pmw_pkg::*;
  logic sysClk = 0, rst = 1, regWr = 0, regRd = 0, energyOn = 0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic [3:0] strapPin = 4'hA, strapVal;
  logic [1:0] anegLocalEee = 0, anegPartnerEee = 0, macLpiReq = 0, linkOn = 0;
  logic [1:0] refreshOn = 0, dataOn = 0, linkUpPin, rxCodeValid, rxCodeRefresh;
  logic [1:0] txLpi, txRefresh, rxLpi, rxClkStop;
  logic [2:0] portPowerDown;
  logic       cableEnergy, hostIrqN, powerEventN;
  logic       pktSof = 0, pktValid = 0;
  logic [7:0] pktByte = 8'h00;
  pmw_rx_s    rxByte;
  pmw_pwr_s   pwr;
  int fails = 0, n_compared = 0, cyc = 0;

  pmw_power_wake_ctrl #(.REFRESH_PERIOD_CYC(4400), .LINK_PULSE_CYC(50)) dut_u (
    .sys_clk(sysClk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .cableEnergy(cableEnergy),
    .linkUpPin(linkUpPin), .strapPin(strapPin), .anegLocalEee(anegLocalEee),
    .anegPartnerEee(anegPartnerEee), .macLpiReq(macLpiReq), .rxCodeValid(rxCodeValid),
    .rxCodeRefresh(rxCodeRefresh), .rxByte(rxByte), .pwr(pwr),
    .portPowerDown(portPowerDown), .strapVal(strapVal), .txLpi(txLpi),
    .txRefresh(txRefresh), .rxLpi(rxLpi), .rxClkStop(rxClkStop),
    .hostIrqN(hostIrqN), .powerEventN(powerEventN));

  pmw_link_partner peer_u (
    .sys_clk(sysClk), .energyOn(energyOn), .linkOn(linkOn), .refreshOn(refreshOn),
    .dataOn(dataOn), .pktSof(pktSof), .pktValid(pktValid), .pktByte(pktByte),
    .cableEnergy(cableEnergy), .linkUpPin(linkUpPin),
    .rxCodeValid(rxCodeValid), .rxCodeRefresh(rxCodeRefresh), .rxByte(rxByte));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  always #25 sysClk = ~sysClk;
  // Longest wait is one transmit refresh period, far below this ceiling
  always @(posedge sysClk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sysClk) {regWr, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge sysClk) regWr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdv(input logic [7:0] a, output logic [7:0] v);
    @(posedge sysClk) {regRd, regAddr} <= {1'b1, a};
    @(posedge sysClk) regRd <= 1'b0;
    #1 v = regRdData;
  endtask : rdv
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rdv(a, v);
    chk(v, exp);
  endtask : rd
  // Bounded poll of the status register
  task automatic poll(input logic [7:0] exp, input int lim);
    logic [7:0] v;
    for (int i = 0; i < lim; i++) begin
      rdv(REG_STATUS, v);
      if ((v & 8'h03) === exp) break;
    end
    chk(v & 8'h03, exp);
  endtask : poll
  // Returns just after the edge so registered outputs have settled
  task automatic cycles(input int n);
    repeat (n) @(posedge sysClk);
    #1;
  endtask : cycles

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_energy_detect_powerdown();
    wr(REG_ED_TMO, 8'h01);
    wr(REG_PWR_CTRL, 8'h08);
    poll(8'h03, 200);
    chk({5'h0, pwr.pllEn, pwr.macEn, pwr.edOnly}, 8'h01);
    for (int i = 0; i < 120 && !pwr.linkPulse; i++) cycles(1);
    chk({7'h0, pwr.linkPulse}, 8'h01);
    // Two cycles of energy is only 100 ns: too short to wake
    @(posedge sysClk) energyOn <= 1'b1;
    cycles(1);
    @(posedge sysClk) energyOn <= 1'b0;
    cycles(8);
    rd(REG_STATUS, 8'h03);
    @(posedge sysClk) energyOn <= 1'b1;
    poll(8'h01, 10);
    wr(REG_PWR_CTRL, 8'h00);
    rd(REG_STATUS, 8'h00);
    $display("energy-detect test done");
  endtask : t_energy_detect_powerdown
  task automatic t_eee();
    @(posedge sysClk) {anegLocalEee, anegPartnerEee, macLpiReq} <= {2'b11, 2'b01, 2'b11};
    cycles(4);
    chk({6'h0, txLpi}, 8'h00);
    wr(REG_EEE_CTRL, 8'h03);
    cycles(3);
    chk({4'h0, txLpi, txRefresh}, 8'h05);
    cycles(4100);
    chk({6'h0, txRefresh}, 8'h00);
    cycles(300);
    chk({6'h0, txRefresh}, 8'h01);
    @(posedge sysClk) {macLpiReq, anegPartnerEee} <= {2'b00, 2'b11};
    cycles(3);
    chk({4'h0, txLpi, rxLpi}, 8'h00);
    wr(REG_PORT_PD, 8'h05);
    cycles(1);
    chk({5'h0, portPowerDown}, 8'h05);
    wr(REG_EEE_CTRL, 8'h0F);
    @(posedge sysClk) refreshOn <= 2'b10;
    @(posedge sysClk) refreshOn <= 2'b00;
    for (int i = 0; i < 8 && !rxLpi[1]; i++) cycles(1);
    chk({4'h0, rxLpi, txLpi}, 8'h08);
    cycles(8);
    chk({6'h0, rxClkStop}, 8'h00);
    cycles(1);
    chk({6'h0, rxClkStop}, 8'h02);
    @(posedge sysClk) dataOn <= 2'b10;
    @(posedge sysClk) dataOn <= 2'b00;
    cycles(3);
    chk({6'h0, rxLpi}, 8'h00);
    $display("idle test done");
  endtask : t_eee
  task automatic t_wake();
    @(posedge sysClk) energyOn <= 1'b0;
    wr(REG_WAKE_CFG, 8'h02);
    @(posedge sysClk) linkOn <= 2'b01;
    cycles(6);
    chk({6'h0, hostIrqN, powerEventN}, 8'h01);
    rd(REG_WAKE_STAT, 8'h02);
    wr(REG_WAKE_STAT, 8'h02);
    cycles(3);
    chk({6'h0, hostIrqN, powerEventN}, 8'h03);
    wr(REG_WAKE_TIME, 8'h01);
    wr(REG_WAKE_CFG, 8'h11);
    @(posedge sysClk) energyOn <= 1'b1;
    cycles(300);
    chk({6'h0, hostIrqN, powerEventN}, 8'h02);
    $display("wake test done");
  endtask : t_wake
  task automatic t_packet();
    for (int i = 0; i < NSTA; i++) wr(REG_STA_BASE + 8'(i), 8'(i + 1));
    wr(REG_WAKE_STAT, 8'h07);
    wr(REG_WAKE_CFG, 8'h04);
    @(posedge sysClk) pktSof <= 1'b1;
    // Six sync bytes, then sixteen copies of the station address
    for (int i = 0; i < 102; i++) begin
      @(posedge sysClk) {pktSof, pktValid} <= 2'b01;
      pktByte <= (i < 6) ? 8'hFF : 8'((i - 6) % 6 + 1);
    end
    @(posedge sysClk) pktValid <= 1'b0;
    cycles(4);
    chk({6'h0, hostIrqN, powerEventN}, 8'h01);
    rd(REG_WAKE_STAT, 8'h04);
    $display("wake packet test done");
  endtask : t_packet
  task automatic t_softpd();
    wr(REG_PWR_CTRL, 8'h10);
    cycles(2);
    chk({5'h0, pwr.pllEn, pwr.phyEn, pwr.macEn}, 8'h00);
    rd(REG_ED_TMO, 8'h01);
    @(posedge sysClk) strapPin <= 4'h5;
    wr(REG_PWR_CTRL, 8'h00);
    cycles(4);
    rd(REG_ED_TMO, ED_TMO_RST);
    rd(REG_PORT_PD, 8'h00);
    chk({4'h0, strapVal}, 8'h05);
    chk({5'h0, pwr.pllEn, pwr.phyEn, pwr.macEn}, 8'h07);
    wr(REG_PWR_CTRL, 8'h18);
    rd(REG_PWR_CTRL, 8'h00);
    $display("soft power-down test done");
  endtask : t_softpd

  initial begin
    repeat (16) @(posedge sysClk);
    rst <= 1'b0;
    cycles(3);
    rd(REG_STATUS, 8'h00);
    rd(REG_ED_TMO, ED_TMO_RST);
    rd(8'h3F, 8'h00);
    chk({2'h0, hostIrqN, powerEventN, strapVal}, 8'h3A);
    $display("reset test done");
    t_energy_detect_powerdown();
    t_eee();
    t_wake();
    t_packet();
    t_softpd();
    end_of_test();
  end
endmodule : tb
